// file: logic/sse_exec.sv
// Functional notes
// - Mode 00 register, 01 indirect, 10 symbolic or indexed, 11 autoincrement.
// - Register zero never indexes; mode 10 with S zero is absolute.
// - Autoincrement adds two to the register after forming the address.
// - Signed product of WR0 and source to WR0 high, WR1 low, bits 0-2.
// - Signed quotient sets overflow when result exceeds 16 bits signed.
// - Otherwise quotient to WR0, remainder with dividend sign to WR1.
// - Trap flag clear vectors via memory; set, not baseline, alternate space.
// - Vector at 0040 plus four times D; new PC at vector plus two.
// - Memory trap writes SA to new WR11, old WP/PC/ST to WR13-15.
// - Memory trap sets bit 6 and clears bits 7-11 after saving.
// - Alternate trap: WP zero, PC from 0812, save old context, clear 7-11.
// - Interrupt input not sampled on trap completion.
// - Context call loads WP from SA, PC from SA+2, saves old context.
// - Interrupt input not sampled on context call completion.
// - Byte swap exchanges halves, writes back, status unchanged.
// - Magnitude compares original to zero, writes absolute value, bits 0-4.
// - Execute runs the instruction at SA; itself changes no status. The code only latches the word at SA in exec_word_q and pulses EXEC_STROBE.
// - Indirect branch loads PC from word at SA, no status change.
// - Execute target read uses operand status code, not instruction fetch.
//
// Local design decisions: the APB slave port and the address map.
module sse_exec (
	input wire logic CLK, // Core clock
	input wire logic RESETN, // Async reset, active low
	input wire logic PSEL, // APB select
	input wire logic PENABLE, // APB enable
	input wire logic PWRITE, // APB direction
	input wire logic [7:0] PADDR, // APB byte address
	input wire logic [31:0] PWDATA, // APB write data
	output logic PREADY, // APB ready
	output logic [31:0] PRDATA, // APB read data
	output logic PSLVERR, // APB error, unmapped
	output sse_pkg::sse_mem_type MEM_BUS, // Memory request
	input wire logic MEM_ACK, // Memory acknowledge
	input wire logic [15:0] MEM_RDATA, // Memory read data
	input wire logic IRQ_INPUT, // Interrupt request level
	output logic IRQ_INHIBIT, // Interrupt test suppressed
	output logic EXEC_STROBE // Execute target word ready
);
	sse_pkg::sse_state_type state_q;
	sse_pkg::sse_mem_type mem_q;
	logic [15:0] ir_q, wp_q, pc_q, st_q, owp_q, opc_q;
	logic [15:0] sa_q, ext_q, regv_q, opnd_q, r0_q, r1_q, exec_word_q;
	logic baseline_q, done_q, irq_seen_q, illegal_q, irq_inhibit_q;
	logic exec_strobe_q, pready_q, pslverr_q;
	logic [31:0] prdata_q;

	logic [9:0] opc10;
	logic [1:0] mode;
	logic [3:0] sfld, dfld;
	logic op_signed_product_op, op_signed_quotient_op, op_bind, op_context_call_op, op_x, op_byte_swap_op, op_abs, op_xop;
	logic alt_trap, mem_done, mem_state;
	logic apb_wr, apb_rd, mapped, start, no_status;
	logic signed [31:0] prod;
	logic signed [32:0] quot, rem;
	logic div_ovf;
	logic [15:0] absval, swapped, vec_addr;
	sse_pkg::sse_state_type after_addr;
	logic [15:0] acc_addr, acc_wdata;
	logic acc_we, acc_alt;
	logic [1:0] acc_bstat;

	function automatic logic [15:0] wr_addr(input logic [15:0] base,
		input logic [3:0] n);
		wr_addr = base + {11'h000, n, 1'b0};
	endfunction : wr_addr

	assign opc10 = ir_q[15:6];
	assign mode = ir_q[5:4];
	assign sfld = ir_q[3:0];
	assign dfld = ir_q[9:6];
	assign op_signed_product_op = opc10 == sse_pkg::OPC_SIGNED_PRODUCT_OP;
	assign op_signed_quotient_op = opc10 == sse_pkg::OPC_SIGNED_QUOTIENT_OP;
	assign op_bind = opc10 == sse_pkg::OPC_BIND;
	assign op_context_call_op = opc10 == sse_pkg::OPC_CONTEXT_CALL_OP;
	assign op_x = opc10 == sse_pkg::OPC_X;
	assign op_byte_swap_op = opc10 == sse_pkg::OPC_BYTE_SWAP_OP;
	assign op_abs = opc10 == sse_pkg::OPC_ABS;
	assign op_xop = ir_q[15:10] == sse_pkg::OPC_XOP;
	assign no_status = op_byte_swap_op | op_x | op_bind;
	// Alternate space only when trap flag set and not baseline
	assign alt_trap = op_xop & st_q[sse_pkg::ST_TRAP_TARGET]
		& ~baseline_q;
	assign vec_addr = sse_pkg::VEC_BASE + {10'h000, dfld, 2'b00};

	// Arithmetic
	assign prod = $signed(r0_q) * $signed(opnd_q);
	always_comb begin
		quot = 33'sh0;
		rem = 33'sh0;
		div_ovf = 1'b1;
		if (opnd_q != 16'h0000) begin
			quot = $signed({r0_q[15], r0_q, r1_q})
				/ $signed({{17{opnd_q[15]}}, opnd_q});
			rem = $signed({r0_q[15], r0_q, r1_q})
				% $signed({{17{opnd_q[15]}}, opnd_q});
			div_ovf = (quot > sse_pkg::Q_MAX)
				|| (quot < sse_pkg::Q_MIN);
		end
	end
	assign absval = opnd_q[15] ? 16'(-opnd_q) : opnd_q;
	assign swapped = {opnd_q[7:0], opnd_q[15:8]};

	// Where addressing hands over once SA is known
	always_comb begin
		if (op_xop) begin
			after_addr = alt_trap ? sse_pkg::S_VPC : sse_pkg::S_VWP;
		end else begin
			after_addr = sse_pkg::S_OPND;
		end
	end

	// Memory access descriptor per state
	always_comb begin
		acc_addr = 16'h0000;
		acc_wdata = 16'h0000;
		acc_we = 1'b0;
		acc_alt = 1'b0;
		acc_bstat = sse_pkg::BST_MEM;
		mem_state = 1'b1;
		case (state_q)
			sse_pkg::S_EXT: begin
				acc_addr = pc_q;
			end
			sse_pkg::S_RREG: begin
				acc_addr = wr_addr(wp_q, sfld);
				acc_bstat = sse_pkg::BST_WS;
			end
			sse_pkg::S_AINC: begin
				acc_addr = wr_addr(wp_q, sfld);
				acc_we = 1'b1;
				acc_wdata = regv_q + sse_pkg::WORD_STEP;
				acc_bstat = sse_pkg::BST_WS;
			end
			sse_pkg::S_VWP: begin
				acc_addr = vec_addr;
			end
			sse_pkg::S_VPC: begin
				if (op_context_call_op) begin
					acc_addr = sa_q + sse_pkg::WORD_STEP;
				end else if (alt_trap) begin
					acc_addr = sse_pkg::ALT_PC_ADDR;
					acc_alt = 1'b1;
				end else begin
					acc_addr = vec_addr + sse_pkg::WORD_STEP;
				end
			end
			sse_pkg::S_OPND: begin
				acc_addr = sa_q;
				acc_bstat = sse_pkg::BST_SOP;
			end
			sse_pkg::S_RD0: begin
				acc_addr = wr_addr(wp_q, sse_pkg::WR_0);
				acc_bstat = sse_pkg::BST_WS;
			end
			sse_pkg::S_RD1: begin
				acc_addr = wr_addr(wp_q, sse_pkg::WR_1);
				acc_bstat = sse_pkg::BST_WS;
			end
			sse_pkg::S_WR0: begin
				// Overflowed divide leaves both registers untouched
				if (op_signed_quotient_op && div_ovf) begin
					mem_state = 1'b0;
				end
				acc_addr = wr_addr(wp_q, sse_pkg::WR_0);
				acc_we = 1'b1;
				acc_wdata = op_signed_product_op ? prod[31:16] : quot[15:0];
				acc_bstat = sse_pkg::BST_WS;
			end
			sse_pkg::S_WR1: begin
				acc_addr = wr_addr(wp_q, sse_pkg::WR_1);
				acc_we = 1'b1;
				acc_wdata = op_signed_product_op ? prod[15:0] : rem[15:0];
				acc_bstat = sse_pkg::BST_WS;
			end
			sse_pkg::S_WRES: begin
				acc_addr = sa_q;
				acc_we = 1'b1;
				acc_wdata = op_byte_swap_op ? swapped : absval;
			end
			sse_pkg::S_W11: begin
				acc_addr = wr_addr(wp_q, sse_pkg::WR_11);
				acc_we = 1'b1;
				acc_wdata = sa_q;
				acc_bstat = sse_pkg::BST_WS;
			end
			sse_pkg::S_W13, sse_pkg::S_W14, sse_pkg::S_W15: begin
				acc_we = 1'b1;
				acc_alt = alt_trap;
				acc_bstat = sse_pkg::BST_WS;
				if (state_q == sse_pkg::S_W13) begin
					acc_addr = wr_addr(wp_q, sse_pkg::WR_13);
					acc_wdata = owp_q;
				end else if (state_q == sse_pkg::S_W14) begin
					acc_addr = wr_addr(wp_q, sse_pkg::WR_14);
					acc_wdata = opc_q;
				end else begin
					acc_addr = wr_addr(wp_q, sse_pkg::WR_15);
					acc_wdata = st_q;
				end
			end
			default: begin
				mem_state = 1'b0;
			end
		endcase
	end

	// Memory handshake: request held until acknowledged
	assign mem_done = mem_q.req & MEM_ACK;
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			mem_q <= '0;
		end else if (mem_done) begin
			mem_q.req <= 1'b0;
		end else if (!mem_q.req && mem_state) begin
			mem_q.req <= 1'b1;
			mem_q.we <= acc_we;
			mem_q.alt <= acc_alt;
			mem_q.bstat <= acc_bstat;
			mem_q.addr <= acc_addr;
			mem_q.wdata <= acc_wdata;
		end
	end

	// APB slave: one wait state, commit on the ready edge
	assign mapped = (PADDR <= sse_pkg::REG_EXEC) && (PADDR[1:0] == 2'b00);
	assign apb_wr = PSEL & PENABLE & PWRITE & pready_q & mapped;
	assign apb_rd = PSEL & PENABLE & ~pready_q;
	assign start = apb_wr && (PADDR == sse_pkg::REG_CTRL)
		&& PWDATA[sse_pkg::CTRL_START];
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= apb_rd;
			pslverr_q <= apb_rd & ~mapped;
			if (apb_rd) begin
				case (PADDR)
					sse_pkg::REG_CTRL:
						prdata_q <= {30'h0, baseline_q, 1'b0};
					sse_pkg::REG_INSTR: prdata_q <= {16'h0000, ir_q};
					sse_pkg::REG_WP: prdata_q <= {16'h0000, wp_q};
					sse_pkg::REG_PC: prdata_q <= {16'h0000, pc_q};
					sse_pkg::REG_ST: prdata_q <= {16'h0000, st_q};
					sse_pkg::REG_STAT: prdata_q <= {27'h0, irq_inhibit_q,
						illegal_q, irq_seen_q, done_q,
						state_q != sse_pkg::S_IDLE};
					sse_pkg::REG_EXEC:
						prdata_q <= {16'h0000, exec_word_q};
					default: prdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Sequencer and architectural state
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			state_q <= sse_pkg::S_IDLE;
			{ir_q, wp_q, pc_q, st_q, owp_q, opc_q} <= '0;
			{sa_q, ext_q, regv_q, opnd_q, r0_q, r1_q, exec_word_q} <= '0;
			{baseline_q, done_q, irq_seen_q, illegal_q} <= '0;
			irq_inhibit_q <= 1'b0;
			exec_strobe_q <= 1'b0;
		end else begin
			exec_strobe_q <= 1'b0;
			if (apb_wr && PADDR == sse_pkg::REG_STAT) begin
				if (PWDATA[sse_pkg::STAT_DONE]) done_q <= 1'b0;
				if (PWDATA[sse_pkg::STAT_IRQ_SEEN]) irq_seen_q <= 1'b0;
			end
			case (state_q)
				sse_pkg::S_IDLE: begin
					if (apb_wr) begin
						case (PADDR)
							sse_pkg::REG_CTRL: baseline_q <=
								PWDATA[sse_pkg::CTRL_BASELINE];
							sse_pkg::REG_INSTR: ir_q <= PWDATA[15:0];
							sse_pkg::REG_WP: wp_q <= PWDATA[15:0];
							sse_pkg::REG_PC: pc_q <= PWDATA[15:0];
							sse_pkg::REG_ST: st_q <= PWDATA[15:0];
							default: ;
						endcase
					end
					if (start) begin
						owp_q <= wp_q;
						opc_q <= pc_q;
						illegal_q <= 1'b0;
						if (!(op_signed_product_op | op_signed_quotient_op | op_bind | op_context_call_op | op_x
							| op_byte_swap_op | op_abs | op_xop)) begin
							illegal_q <= 1'b1;
							state_q <= sse_pkg::S_DONE;
						end else if (mode == sse_pkg::MODE_REG) begin
							sa_q <= wr_addr(wp_q, sfld);
							state_q <= after_addr;
						end else if (mode == sse_pkg::MODE_IDX) begin
							state_q <= sse_pkg::S_EXT;
						end else begin
							state_q <= sse_pkg::S_RREG;
						end
					end
				end
				sse_pkg::S_EXT: if (mem_done) begin
					ext_q <= MEM_RDATA;
					pc_q <= pc_q + sse_pkg::WORD_STEP;
					opc_q <= pc_q + sse_pkg::WORD_STEP;
					if (sfld == sse_pkg::WR_0) begin
						sa_q <= MEM_RDATA;
						state_q <= after_addr;
					end else begin
						state_q <= sse_pkg::S_RREG;
					end
				end
				sse_pkg::S_RREG: if (mem_done) begin
					regv_q <= MEM_RDATA;
					if (mode == sse_pkg::MODE_IDX) begin
						sa_q <= ext_q + MEM_RDATA;
					end else begin
						sa_q <= MEM_RDATA;
					end
					state_q <= (mode == sse_pkg::MODE_INC)
						? sse_pkg::S_AINC : after_addr;
				end
				sse_pkg::S_AINC: if (mem_done) state_q <= after_addr;
				sse_pkg::S_VWP: if (mem_done) begin
					wp_q <= MEM_RDATA;
					state_q <= sse_pkg::S_VPC;
				end
				sse_pkg::S_VPC: if (mem_done) begin
					pc_q <= MEM_RDATA;
					if (alt_trap) wp_q <= 16'h0000;
					state_q <= (op_xop && !alt_trap)
						? sse_pkg::S_W11 : sse_pkg::S_W13;
				end
				sse_pkg::S_OPND: if (mem_done) begin
					opnd_q <= MEM_RDATA;
					if (op_signed_product_op || op_signed_quotient_op) begin
						state_q <= sse_pkg::S_RD0;
					end else if (op_byte_swap_op || op_abs) begin
						state_q <= sse_pkg::S_WRES;
					end else if (op_bind) begin
						pc_q <= MEM_RDATA;
						state_q <= sse_pkg::S_DONE;
					end else if (op_context_call_op) begin
						wp_q <= MEM_RDATA;
						state_q <= sse_pkg::S_VPC;
					end else begin
						exec_word_q <= MEM_RDATA;
						exec_strobe_q <= 1'b1;
						state_q <= sse_pkg::S_DONE;
					end
				end
				sse_pkg::S_RD0: if (mem_done) begin
					r0_q <= MEM_RDATA;
					state_q <= op_signed_product_op ? sse_pkg::S_WR0 : sse_pkg::S_RD1;
				end
				sse_pkg::S_RD1: if (mem_done) begin
					r1_q <= MEM_RDATA;
					state_q <= sse_pkg::S_WR0;
				end
				sse_pkg::S_WR0: begin
					if (op_signed_quotient_op && div_ovf) begin
						state_q <= sse_pkg::S_DONE;
					end else if (mem_done) begin
						state_q <= sse_pkg::S_WR1;
					end
				end
				sse_pkg::S_W11: if (mem_done) state_q <= sse_pkg::S_W13;
				sse_pkg::S_W13: if (mem_done) state_q <= sse_pkg::S_W14;
				sse_pkg::S_W14: if (mem_done) state_q <= sse_pkg::S_W15;
				sse_pkg::S_WR1, sse_pkg::S_WRES, sse_pkg::S_W15: begin
					if (mem_done) state_q <= sse_pkg::S_DONE;
				end
				sse_pkg::S_DONE: begin
					state_q <= sse_pkg::S_IDLE;
					done_q <= 1'b1;
					irq_inhibit_q <= op_xop | op_context_call_op;
					if (!(op_xop | op_context_call_op) && IRQ_INPUT) begin
						irq_seen_q <= 1'b1;
					end
					if (illegal_q) begin
						st_q <= st_q;
					end else if (op_signed_product_op) begin
						st_q[sse_pkg::ST_LGT] <= prod != 32'sh0;
						st_q[sse_pkg::ST_AGT] <= prod > 32'sh0;
						st_q[sse_pkg::ST_EQ] <= prod == 32'sh0;
					end else if (op_signed_quotient_op && div_ovf) begin
						st_q[sse_pkg::ST_OVF] <= 1'b1;
					end else if (op_signed_quotient_op) begin
						st_q[sse_pkg::ST_LGT] <= quot != 33'sh0;
						st_q[sse_pkg::ST_AGT] <= quot > 33'sh0;
						st_q[sse_pkg::ST_EQ] <= quot == 33'sh0;
						st_q[sse_pkg::ST_OVF] <= 1'b0;
					end else if (op_abs) begin
						st_q[sse_pkg::ST_LGT] <= opnd_q != 16'h0000;
						st_q[sse_pkg::ST_AGT] <= !opnd_q[15]
							&& opnd_q != 16'h0000;
						st_q[sse_pkg::ST_EQ] <= opnd_q == 16'h0000;
						st_q[sse_pkg::ST_CARRY] <= 1'b0;
						st_q[sse_pkg::ST_OVF] <= opnd_q == sse_pkg::MIN_NEG;
					end else if (op_xop) begin
						st_q[sse_pkg::ST_CLR_HI:sse_pkg::ST_CLR_LO] <= '0;
						if (!alt_trap) begin
							st_q[sse_pkg::ST_TRAP_ENTERED] <= 1'b1;
						end
					end
				end
				default: state_q <= sse_pkg::S_IDLE;
			endcase
		end
	end

	assign MEM_BUS = mem_q;
	assign PREADY = pready_q;
	assign PRDATA = prdata_q;
	assign PSLVERR = pslverr_q;
	assign IRQ_INHIBIT = irq_inhibit_q;
	assign EXEC_STROBE = exec_strobe_q;

	// Checks
	default clocking cb_core @(posedge CLK);
	endclocking
	default disable iff (!RESETN);
	sequence s_trap_finish;
		state_q == sse_pkg::S_DONE && op_xop && !illegal_q;
	endsequence
	a_autoinc_plus_two: assert property (
		(mem_q.req && state_q == sse_pkg::S_AINC) |->
		mem_q.wdata == 16'(regv_q + 16'h0002))
		else $error("autoincrement not by two");
	a_vector_address: assert property (
		(mem_q.req && state_q == sse_pkg::S_VWP) |->
		mem_q.addr == 16'(16'h0040 + {dfld, 2'b00}))
		else $error("trap vector address wrong");
	a_alt_pc_fetch: assert property (
		(mem_q.req && state_q == sse_pkg::S_VPC && alt_trap) |->
		mem_q.addr == 16'h0812 && mem_q.alt)
		else $error("alternate pc fetch wrong");
	a_trap_irq_hold: assert property (
		(state_q == sse_pkg::S_DONE && (op_xop || op_context_call_op)) |=>
		IRQ_INHIBIT && $stable(irq_seen_q))
		else $error("interrupt sampled after context change");
	a_swap_result: assert property (
		(mem_q.req && state_q == sse_pkg::S_WRES && op_byte_swap_op) |->
		mem_q.wdata == {opnd_q[7:0], opnd_q[15:8]})
		else $error("byte swap result wrong");
	a_product_low: assert property (
		(mem_q.req && state_q == sse_pkg::S_WR1 && op_signed_product_op) |->
		mem_q.wdata == 16'(r0_q * opnd_q))
		else $error("product low half wrong");
	a_status_kept: assert property (
		(state_q != sse_pkg::S_IDLE && no_status) |=> $stable(st_q))
		else $error("status changed by no-status op");
	a_div_overflow: assert property (
		(state_q == sse_pkg::S_DONE && op_signed_quotient_op && div_ovf && !illegal_q)
		|=> st_q[sse_pkg::ST_OVF] ##1 state_q == sse_pkg::S_IDLE)
		else $error("divide overflow not flagged");
	a_trap_flags: assert property (
		s_trap_finish and !alt_trap |=> st_q[sse_pkg::ST_TRAP_ENTERED]
		&& st_q[8:4] == 5'h00)
		else $error("trap status flags wrong");
	a_symbolic_abs: assert property (
		(state_q == sse_pkg::S_EXT && mem_done && sfld == 4'h0) |=>
		sa_q == $past(MEM_RDATA) && state_q != sse_pkg::S_RREG)
		else $error("symbolic address indexed");
endmodule : sse_exec

// file: common/sse_pkg.sv
package sse_pkg;
	// APB register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_INSTR = 8'h04;
	localparam logic [7:0] REG_WP = 8'h08;
	localparam logic [7:0] REG_PC = 8'h0c;
	localparam logic [7:0] REG_ST = 8'h10;
	localparam logic [7:0] REG_STAT = 8'h14;
	localparam logic [7:0] REG_EXEC = 8'h18;
	// Field positions
	localparam int CTRL_START = 0;
	localparam int CTRL_BASELINE = 1;
	localparam int STAT_BUSY = 0;
	localparam int STAT_DONE = 1;
	localparam int STAT_IRQ_SEEN = 2;
	localparam int STAT_ILLEGAL = 3;
	localparam int STAT_IRQ_INHIBIT = 4;
	// Status word bit n is stored at index 15-n
	localparam int ST_LGT = 15;
	localparam int ST_AGT = 14;
	localparam int ST_EQ = 13;
	localparam int ST_CARRY = 12;
	localparam int ST_OVF = 11;
	localparam int ST_TRAP_ENTERED = 9;
	localparam int ST_CLR_HI = 8;
	localparam int ST_CLR_LO = 4;
	localparam int ST_TRAP_TARGET = 4;
	// Opcodes, instruction bits 15:6 (bits 0..9 in MSB-first numbering); OPC_XOP is bits 15:10 only
	localparam logic [9:0] OPC_SIGNED_PRODUCT_OP = 10'h007;
	localparam logic [9:0] OPC_SIGNED_QUOTIENT_OP = 10'h006;
	localparam logic [9:0] OPC_BIND = 10'h005;
	localparam logic [9:0] OPC_CONTEXT_CALL_OP = 10'h010;
	localparam logic [9:0] OPC_X = 10'h012;
	localparam logic [9:0] OPC_BYTE_SWAP_OP = 10'h01b;
	localparam logic [9:0] OPC_ABS = 10'h01d;
	localparam logic [5:0] OPC_XOP = 6'h0b;
	// Source modes
	localparam logic [1:0] MODE_REG = 2'h0;
	localparam logic [1:0] MODE_IND = 2'h1;
	localparam logic [1:0] MODE_IDX = 2'h2;
	localparam logic [1:0] MODE_INC = 2'h3;
	// Addresses and constants
	localparam logic [15:0] VEC_BASE = 16'h0040;
	localparam logic [15:0] ALT_PC_ADDR = 16'h0812;
	localparam logic [15:0] WORD_STEP = 16'h0002;
	localparam logic [3:0] WR_0 = 4'h0;
	localparam logic [3:0] WR_1 = 4'h1;
	localparam logic [3:0] WR_11 = 4'hb;
	localparam logic [3:0] WR_13 = 4'hd;
	localparam logic [3:0] WR_14 = 4'he;
	localparam logic [3:0] WR_15 = 4'hf;
	localparam logic [15:0] MIN_NEG = 16'h8000;
	localparam logic signed [32:0] Q_MAX = 33'sh0_0000_7fff;
	localparam logic signed [32:0] Q_MIN = -33'sh0_0000_8000;
	// Bus status codes
	localparam logic [1:0] BST_MEM = 2'h0;
	localparam logic [1:0] BST_WS = 2'h1;
	localparam logic [1:0] BST_SOP = 2'h2;

	typedef enum logic [16:0] {
		S_IDLE = 17'h00001,
		S_EXT = 17'h00002,
		S_RREG = 17'h00004,
		S_AINC = 17'h00008,
		S_VWP = 17'h00010,
		S_VPC = 17'h00020,
		S_OPND = 17'h00040,
		S_RD0 = 17'h00080,
		S_RD1 = 17'h00100,
		S_WR0 = 17'h00200,
		S_WR1 = 17'h00400,
		S_WRES = 17'h00800,
		S_W11 = 17'h01000,
		S_W13 = 17'h02000,
		S_W14 = 17'h04000,
		S_W15 = 17'h08000,
		S_DONE = 17'h10000
	} sse_state_type;

	typedef struct packed {
		logic req;
		logic we;
		logic alt;
		logic [1:0] bstat;
		logic [15:0] addr;
		logic [15:0] wdata;
	} sse_mem_type;
endpackage : sse_pkg

// file: sim/sse_exec_test.sv
module sse_exec_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLK, RESETN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
	logic MEM_ACK, IRQ_INPUT, IRQ_INHIBIT, EXEC_STROBE;
	logic [7:0] PADDR;
	logic [31:0] PWDATA, PRDATA, rd;
	logic [15:0] MEM_RDATA;
	sse_pkg::sse_mem_type MEM_BUS;
	logic [15:0] mem [0:32767];
	logic [15:0] alt [0:32767];
	logic err_seen, strobe_seen, base_mode;
	logic [1:0] rd_stat;
	int bad_count, total_checks;

	sse_exec uut (.CLK(CLK), .RESETN(RESETN), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
		.PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA),
		.PSLVERR(PSLVERR), .MEM_BUS(MEM_BUS), .MEM_ACK(MEM_ACK),
		.MEM_RDATA(MEM_RDATA), .IRQ_INPUT(IRQ_INPUT),
		.IRQ_INHIBIT(IRQ_INHIBIT), .EXEC_STROBE(EXEC_STROBE));

	initial begin
		CLK = 1'h0;
		forever #2 CLK = ~CLK;
	end

	// Word memory; data bus shows garbage outside an acknowledged read
	always @(posedge CLK) begin
		MEM_ACK <= 1'h0;
		MEM_RDATA <= ~MEM_RDATA;
		if (MEM_BUS.req === 1'h1 && !MEM_ACK) begin
			MEM_ACK <= 1'h1;
			if (MEM_BUS.we && MEM_BUS.alt)
				alt[MEM_BUS.addr[15:1]] <= MEM_BUS.wdata;
			else if (MEM_BUS.we)
				mem[MEM_BUS.addr[15:1]] <= MEM_BUS.wdata;
			else begin
				MEM_RDATA <= MEM_BUS.alt ? alt[MEM_BUS.addr[15:1]] :
					mem[MEM_BUS.addr[15:1]];
				rd_stat <= MEM_BUS.bstat;
			end
		end
		if (EXEC_STROBE === 1'h1)
			strobe_seen <= 1'h1;
	end

	task check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK);
		PSEL <= 1'h1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'h1;
		// Sample mid-cycle, release after the ready edge
		do @(negedge CLK); while (PREADY !== 1'h1);
		rd = PRDATA;
		err_seen = PSLVERR;
		@(posedge CLK);
		PSEL <= 1'h0;
		PENABLE <= 1'h0;
	endtask : apb

	task rdreg(input logic [7:0] a, input logic [31:0] exp);
		apb(1'h0, a, 32'h0);
		check(rd, exp);
	endtask : rdreg

	// Workspace at 0100, PC at 0080; leaves STAT in rd
	task run(input logic [15:0] ins, input logic [15:0] st);
		apb(1'h1, sse_pkg::REG_STAT, 32'h6);
		apb(1'h1, sse_pkg::REG_WP, 32'h0100);
		apb(1'h1, sse_pkg::REG_PC, 32'h0080);
		apb(1'h1, sse_pkg::REG_ST, {16'h0, st});
		apb(1'h1, sse_pkg::REG_INSTR, {16'h0, ins});
		apb(1'h1, sse_pkg::REG_CTRL, {30'h0, base_mode, 1'h1});
		do apb(1'h0, sse_pkg::REG_STAT, 32'h0);
		while (rd[sse_pkg::STAT_DONE] !== 1'h1);
	endtask : run

	task t_mpy;
		mem[15'h80] = 16'hfffd;
		mem[15'h82] = 16'h0007;
		run({sse_pkg::OPC_SIGNED_PRODUCT_OP, sse_pkg::MODE_REG, 4'h2}, 16'h0);
		check(mem[15'h80], 16'hffff);
		check(mem[15'h81], 16'hffeb);
		rdreg(sse_pkg::REG_ST, 32'h8000);
		$display("signed product test done");
	endtask : t_mpy

	task t_div;
		mem[15'h80] = 16'hffff;
		mem[15'h81] = 16'hffeb;
		mem[15'h83] = 16'h0200;
		mem[15'h100] = 16'h0004;
		run({sse_pkg::OPC_SIGNED_QUOTIENT_OP, sse_pkg::MODE_INC, 4'h3}, 16'h0);
		check(mem[15'h80], 16'hfffb);
		check(mem[15'h81], 16'hffff);
		check(mem[15'h83], 16'h0202);
		check(rd[sse_pkg::STAT_ILLEGAL], 1'h0);
		apb(1'h0, sse_pkg::REG_ST, 32'h0);
		check(rd[sse_pkg::ST_OVF], 1'h0);
		mem[15'h80] = 16'hffff;
		mem[15'h81] = 16'h8000;
		mem[15'h82] = 16'h0001;
		run({sse_pkg::OPC_SIGNED_QUOTIENT_OP, sse_pkg::MODE_REG, 4'h2}, 16'h0);
		check(mem[15'h80], 16'h8000);
		apb(1'h0, sse_pkg::REG_ST, 32'h0);
		check(rd[sse_pkg::ST_OVF], 1'h0);
		// Would fit if register zero were wrongly added as index
		mem[15'h80] = 16'h0002;
		mem[15'h81] = 16'h0000;
		mem[15'h40] = 16'h0300;
		mem[15'h180] = 16'h0001;
		mem[15'h181] = 16'h7fff;
		run({sse_pkg::OPC_SIGNED_QUOTIENT_OP, sse_pkg::MODE_IDX, 4'h0}, 16'h0);
		apb(1'h0, sse_pkg::REG_ST, 32'h0);
		check(rd[sse_pkg::ST_OVF], 1'h1);
		$display("signed quotient test done");
	endtask : t_div

	task t_trap;
		mem[15'h24] = 16'h0500;
		mem[15'h25] = 16'h0600;
		IRQ_INPUT <= 1'h1;
		run({sse_pkg::OPC_XOP, 4'h2, sse_pkg::MODE_REG, 4'h5}, 16'h01e0);
		check(rd[sse_pkg::STAT_IRQ_SEEN], 1'h0);
		check(IRQ_INHIBIT, 1'h1);
		rdreg(sse_pkg::REG_WP, 32'h0500);
		rdreg(sse_pkg::REG_PC, 32'h0600);
		rdreg(sse_pkg::REG_ST, 32'h0200);
		check(mem[15'h28b], 16'h010a);
		check(mem[15'h28d], 16'h0100);
		check(mem[15'h28e], 16'h0080);
		check(mem[15'h28f], 16'h01e0);
		IRQ_INPUT <= 1'h0;
		alt[15'h409] = 16'h0900;
		run({sse_pkg::OPC_XOP, 4'h1, sse_pkg::MODE_REG, 4'h0}, 16'h01f0);
		rdreg(sse_pkg::REG_WP, 32'h0);
		rdreg(sse_pkg::REG_PC, 32'h0900);
		rdreg(sse_pkg::REG_ST, 32'h0);
		check(alt[15'hd], 16'h0100);
		check(alt[15'he], 16'h0080);
		check(alt[15'hf], 16'h01f0);
		base_mode = 1'h1;
		apb(1'h1, sse_pkg::REG_CTRL, 32'h2);
		run({sse_pkg::OPC_XOP, 4'h2, sse_pkg::MODE_REG, 4'h5}, 16'h01f0);
		rdreg(sse_pkg::REG_WP, 32'h0500);
		base_mode = 1'h0;
		apb(1'h1, sse_pkg::REG_CTRL, 32'h0);
		$display("extended trap test done");
	endtask : t_trap

	task t_call;
		mem[15'h88] = 16'h0700;
		mem[15'h380] = 16'h0a00;
		mem[15'h381] = 16'h0b00;
		IRQ_INPUT <= 1'h1;
		run({sse_pkg::OPC_CONTEXT_CALL_OP, sse_pkg::MODE_IND, 4'h8}, 16'h0);
		check(rd[sse_pkg::STAT_IRQ_SEEN], 1'h0);
		check(IRQ_INHIBIT, 1'h1);
		IRQ_INPUT <= 1'h0;
		rdreg(sse_pkg::REG_WP, 32'h0a00);
		rdreg(sse_pkg::REG_PC, 32'h0b00);
		check(mem[15'h50d], 16'h0100);
		check(mem[15'h50e], 16'h0080);
		$display("context call test done");
	endtask : t_call

	task t_unary;
		mem[15'h86] = 16'h12ab;
		mem[15'h87] = 16'h8003;
		IRQ_INPUT <= 1'h1;
		run({sse_pkg::OPC_BYTE_SWAP_OP, sse_pkg::MODE_REG, 4'h6}, 16'hf800);
		check(rd[sse_pkg::STAT_IRQ_SEEN], 1'h1);
		check(IRQ_INHIBIT, 1'h0);
		IRQ_INPUT <= 1'h0;
		check(mem[15'h86], 16'hab12);
		rdreg(sse_pkg::REG_ST, 32'hf800);
		run({sse_pkg::OPC_ABS, sse_pkg::MODE_REG, 4'h7}, 16'h7800);
		check(mem[15'h87], 16'h7ffd);
		rdreg(sse_pkg::REG_ST, 32'h8000);
		$display("swap and magnitude test done");
	endtask : t_unary

	task t_branch;
		mem[15'h89] = 16'h0800;
		mem[15'h400] = 16'hbeef;
		strobe_seen <= 1'h0;
		run({sse_pkg::OPC_X, sse_pkg::MODE_IND, 4'h9}, 16'h5000);
		rdreg(sse_pkg::REG_EXEC, 32'hbeef);
		check(strobe_seen, 1'h1);
		check(rd_stat, sse_pkg::BST_SOP);
		rdreg(sse_pkg::REG_ST, 32'h5000);
		mem[15'h84] = 16'h0004;
		mem[15'h40] = 16'h0400;
		mem[15'h202] = 16'h1234;
		run({sse_pkg::OPC_BIND, sse_pkg::MODE_IDX, 4'h4}, 16'h5000);
		rdreg(sse_pkg::REG_PC, 32'h1234);
		rdreg(sse_pkg::REG_ST, 32'h5000);
		apb(1'h0, 8'h1c, 32'h0);
		check(err_seen, 1'h1);
		$display("execute and branch test done");
	endtask : t_branch

	task complete_run;
		$display("Checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run

	initial begin
		#100000;
		bad_count++;
		complete_run;
	end

	initial begin
		RESETN = 1'h0;
		PSEL = 1'h0;
		PENABLE = 1'h0;
		PWRITE = 1'h0;
		PADDR = 8'h0;
		PWDATA = 32'h0;
		MEM_RDATA = 16'h0;
		IRQ_INPUT = 1'h0;
		strobe_seen = 1'h0;
		base_mode = 1'h0;
		repeat (2) @(posedge CLK);
		RESETN <= 1'h1;
		t_mpy;
		t_div;
		t_trap;
		t_call;
		t_unary;
		t_branch;
		complete_run;
	end
endmodule : sse_exec_test
